// ### logic/dsl_pkg.sv
// package of constants for the serial-load dac input logic
package dsl_pkg;
   localparam int WORD_W = 16;
   localparam logic [15:0] DAC_RST = 16'h0000;
   localparam int SYNC_STAGES = 2;
endpackage

// ### logic/dsl_sync.sv
// two flip-flop level synchroniser with clock enable
`timescale 1ns/100ps
module dsl_sync (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta_reg;
   logic meta_next;
   logic q_reg;
   logic q_next;

   always_comb begin
      meta_next = meta_reg;
      q_next = q_reg;
      if (rst_i) begin
         meta_next = 1'b1;
         q_next = 1'b1;
      end else if (ce_i) begin
         meta_next = d_i;
         q_next = meta_reg;
      end
   end

   always_ff @(posedge clock_i) begin
      meta_reg <= meta_next;
      q_reg <= q_next;
   end

   assign q_o = q_reg;
endmodule

// ### logic/dsl_top.sv
// serial input register, frame end detection and dac register update
`timescale 1ns/100ps
// Function
// RULE1 - power-up clears dac register to zero
// RULE2 - serial register not reset at power-up
// RULE3 - over-long frame keeps last sixteen bits
// RULE4 - short frame keeps previous leftover bits
// RULE5 - host loads sixteen bits first time
// RULE6 - host pads short words with zeros; the bench sends an unpadded 8-bit frame instead
// RULE7 - data sampled on rising serial clock
// RULE8 - host drives clock, data, select, load
// RULE9 - host selects one device at once
// RULE10 - host bursts serial clock only
// RULE11 - shift only while chip select low
// RULE12 - select rise loads dac if load low
// RULE13 - load strobe pulse copies to dac
// RULE14 - word assembled most significant first
// RULE15 - all sixteen dac bits update together
module dsl_top (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic sclk_i,
   input wire logic sdata_i,
   input wire logic cs_n_i,
   input wire logic load_strobe_n_i,
   output logic [15:0] dac_code_o,
   output logic load_done_o
);
   // ************************************************************
   // link domain: serial input register
   // ************************************************************
   // no reset here on purpose: contents stay undefined until shifted
   logic [15:0] shift_reg;
   logic [15:0] shift_next;

   // RULE7 RULE11 RULE14 RULE3 RULE4 - msb-first shift while selected
   // bit 0 takes the pin, every other bit its lower neighbour, so the
   // oldest bit drops off the top and a long frame keeps its last word
   assign shift_next[0] = cs_n_i ? shift_reg[0] : sdata_i;

   for (genvar i = 1; i < dsl_pkg::WORD_W; i++) begin : g_shift
      assign shift_next[i] = cs_n_i ? shift_reg[i] : shift_reg[i - 1];
   end

   // RULE2 - shift register has no reset
   always_ff @(posedge sclk_i) begin
      shift_reg <= shift_next;
   end

   // ************************************************************
   // crossing of the word into the system clock
   // ************************************************************
   // sclk may stop after a frame, so the word is loaded from the system
   // domain stages only once the select rise has been seen synchronised; the
   // shift register is quiet then because it only shifts while select is low.
   // a host that runs sclk while select is high leaves the word unchanged
   // under the capture stages, so such a load is not torn.
   // select and strobe are pins of their own and pass two flops first.

   logic cs_n_s;
   logic load_n_s;

   dsl_sync u_cs_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(cs_n_i),
      .q_o(cs_n_s)
   );

   dsl_sync u_ld_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(load_strobe_n_i),
      .q_o(load_n_s)
   );

   // ************************************************************
   // system domain: edge detect and dac register
   // ************************************************************
   // true on the cycle in which a synchronised level leaves its idle high;
   // the select rise is fed in with its arguments swapped
   function automatic logic dsl_left_idle(input logic now_v, input logic was_v);
      dsl_left_idle = ~now_v & was_v;
   endfunction

   logic cs_n_d_reg;
   logic cs_n_d_next;
   logic load_n_d_reg;
   logic load_n_d_next;
   logic cs_rise;
   logic load_fall;

   // delay flops start at the pins' idle high, so no false edge after reset
   always_comb begin
      cs_n_d_next = cs_n_d_reg;
      load_n_d_next = load_n_d_reg;
      if (rst_i) begin
         cs_n_d_next = 1'b1;
         load_n_d_next = 1'b1;
      end else if (ce_i) begin
         cs_n_d_next = cs_n_s;
         load_n_d_next = load_n_s;
      end
   end

   always_ff @(posedge clock_i) begin
      cs_n_d_reg <= cs_n_d_next;
      load_n_d_reg <= load_n_d_next;
   end

   always_comb begin
      cs_rise = dsl_left_idle(cs_n_d_reg, cs_n_s);
      load_fall = dsl_left_idle(load_n_s, load_n_d_reg);
   end

   // two stages keep the sampling off the link-side edge; the word is
   // quiet while select is high, which both load paths rely on
   logic [15:0] word_s1_reg;
   logic [15:0] word_s1_next;
   logic [15:0] word_s2_reg;
   logic [15:0] word_s2_next;

   always_comb begin
      word_s1_next = word_s1_reg;
      word_s2_next = word_s2_reg;
      if (ce_i) begin
         word_s1_next = shift_reg;
         word_s2_next = word_s1_reg;
      end
   end

   always_ff @(posedge clock_i) begin
      word_s1_reg <= word_s1_next;
      word_s2_reg <= word_s2_next;
   end

   // ************************************************************
   // load control: one settle cycle after the select rise
   // ************************************************************
   // the extra cycle lets the capture stages take the final word even
   // when the host raises select soon after its last clock edge
   typedef enum logic [1:0] {st_idle, st_frame, st_settle} dsl_state_t;

   dsl_state_t state_reg;
   dsl_state_t state_next;
   logic frame_load_reg;
   logic frame_load_next;

   always_comb begin
      state_next = state_reg;
      frame_load_next = frame_load_reg;
      if (rst_i) begin
         state_next = st_idle;
         frame_load_next = 1'b0;
      end else if (ce_i) begin
         case (state_reg)
            st_idle: begin
               if (!cs_n_s) begin
                  state_next = st_frame;
               end
            end
            st_frame: begin
               if (cs_rise) begin
                  // RULE12 - strobe level at the select rise decides
                  frame_load_next = ~load_n_s;
                  state_next = st_settle;
               end
            end
            st_settle: begin
               state_next = st_idle;
            end
            default: begin
               state_next = st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      state_reg <= state_next;
      frame_load_reg <= frame_load_next;
   end

   // ************************************************************
   // dac register
   // ************************************************************
   logic [15:0] dac_reg;
   logic [15:0] dac_next;
   logic done_reg;
   logic done_next;
   logic take_frame;
   logic take_strobe;

   always_comb begin
      take_frame = (state_reg == st_settle) & frame_load_reg;
      // RULE13 - strobe falling edge loads outside frames only
      take_strobe = load_fall & cs_n_s & (state_reg == st_idle);
   end

   always_comb begin
      dac_next = dac_reg;
      done_next = 1'b0;
      if (rst_i) begin
         // RULE1 - power-up clears the dac code
         dac_next = dsl_pkg::DAC_RST;
      end else if (ce_i) begin
         if (take_frame || take_strobe) begin
            dac_next = word_s2_reg;
            done_next = 1'b1;
         end
      end
   end

   // RULE15 - whole word in one register write
   always_ff @(posedge clock_i) begin
      dac_reg <= dac_next;
      done_reg <= done_next;
   end

   assign dac_code_o = dac_reg;
   assign load_done_o = done_reg;
endmodule

// ### tb/dsl_host.sv
// host model of the serial link
`timescale 1ns/100ps
module dsl_host (
   output logic sclk_o,
   output logic sdata_o,
   output logic cs_n_o,
   output logic load_strobe_n_o
);
   initial begin
      {sclk_o, sdata_o, cs_n_o, load_strobe_n_o} = 4'h3;
   end
   // msb first, clock only in frames
   task automatic send(input logic [31:0] w, input int n);
      cs_n_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdata_o = w[i];
         #24 sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
      end
      #24 cs_n_o = 1'b1;
      // no pull on data: show the inverse once released
      sdata_o = ~sdata_o;
   endtask
endmodule

// ### tb/dsl_top_assertions.sv
// checker of the dac register update
`timescale 1ns/100ps
module dsl_top_checker (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cs_n_i,
   input wire logic load_strobe_n_i,
   input wire logic [15:0] dac_code_o,
   input wire logic load_done_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_reset_zero: assert property ($fell(rst_i) |-> dac_code_o == 16'h0000)
      else $error("code not zero");
   a_code_whole: assert property ($changed(dac_code_o) |-> load_done_o)
      else $error("code moved alone");
   a_done_pulse: assert property (load_done_o && ce_i |=> !load_done_o)
      else $error("long pulse");
   a_frame_load: assert property ($rose(cs_n_i) && !load_strobe_n_i |-> ##[3:7] load_done_o)
      else $error("no frame load");
   a_strobe_load: assert property ($fell(load_strobe_n_i) && cs_n_i |-> ##[2:6] load_done_o)
      else $error("no strobe load");
   a_idle_quiet: assert property ((cs_n_i && load_strobe_n_i)[*8] |=> !load_done_o)
      else $error("load with strobe high");
   a_frame_quiet: assert property ((!cs_n_i)[*8] |=> !load_done_o)
      else $error("load in frame");
   a_ce_hold: assert property (!ce_i |=> $stable(dac_code_o))
      else $error("code moved without enable");
   c_frame: cover property ($rose(cs_n_i) && !load_strobe_n_i);
   c_strobe: cover property ($fell(load_strobe_n_i));
   c_done: cover property (load_done_o);
endmodule
bind dsl_top dsl_top_checker u_chk (.clock_i, .rst_i, .ce_i, .cs_n_i, .load_strobe_n_i,
   .dac_code_o, .load_done_o);

// ### tb/dsl_top_tb.sv
// self-checking bench of the dac input logic
`timescale 1ns/100ps
module dsl_top_tb;
   logic clock_i, rst_i, ce_i, sclk, sdata, cs_n, lds_n, done;
   logic [15:0] code;
   int err_count = 0;
   int checks_done = 0;
   dsl_top u_dsl_top (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .sclk_i(sclk),
      .sdata_i(sdata), .cs_n_i(cs_n), .load_strobe_n_i(lds_n), .dac_code_o(code),
      .load_done_o(done));
   dsl_host u_dsl_host (.sclk_o(sclk), .sdata_o(sdata), .cs_n_o(cs_n),
      .load_strobe_n_o(lds_n));
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // bounded wait for the update pulse, then judge the code; the gap
   // after it keeps select high long enough before the next frame
   task automatic settle(input logic [15:0] exp);
      for (int n = 0; n < 20 && done !== 1'b1; n++) begin
         @(negedge clock_i);
      end
      cmp_bit(done, 1'b1);
      cmp(code, exp);
      repeat (4) @(negedge clock_i);
   endtask
   task automatic t_frame();
      u_dsl_host.send(32'h0000a5c3, 16);
      repeat (4) @(negedge clock_i);
      u_dsl_host.load_strobe_n_o = 1'b0;
      settle(16'ha5c3);
      u_dsl_host.send(32'h0003c96e, 20);
      settle(16'hc96e);
      u_dsl_host.send(32'h0000007f, 8);
      settle(16'h6e7f);
      u_dsl_host.send(32'h00005a00, 16);
      settle(16'h5a00);
      $display("t_frame done");
   endtask
   task automatic t_strobe();
      u_dsl_host.load_strobe_n_o = 1'b1;
      repeat (4) @(negedge clock_i);
      u_dsl_host.send(32'h00001357, 16);
      repeat (12) @(negedge clock_i);
      cmp(code, 16'h5a00);
      ce_i = 1'b0;
      u_dsl_host.load_strobe_n_o = 1'b0;
      repeat (3) @(negedge clock_i);
      cmp(code, 16'h5a00);
      ce_i = 1'b1;
      settle(16'h1357);
      $display("t_strobe done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #40000;
      err_count++;
      results();
   end
   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      repeat (10) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clock_i);
      cmp(code, 16'h0000);
      t_frame();
      t_strobe();
      results();
   end
endmodule
